/* rtl/srt_router.sv */
// Sync line and trigger routing matrix of the interface card.
// How it works
// - each connect joins one source to one destination.
// - closing a port releases all its connections.
// - first generation chassis hides sync line 6.
// - high-speed-only cards allow four in, four out.
// - low-speed cards allow two in, three out.
// - fault event port 1 even, port 2 odd.
// - plain PCI lacks chassis star and reference.
// - PCMCIA lacks 20 MHz timebase, star, reference.
// - PCMCIA lacks sync lines 4, 5, 6.
// - USB variant uses only line 0 and clock.
// - USB exports 1 MHz, accepts 20 MHz.
// - first generation permitted route set.
// - second generation adds further permitted routes.
// - USB variant permitted route set only.
// - start trigger fires on first rising edge.
// - resync pulse on every resync rising edge.
// - receive event pulse is routed unchanged.
`timescale 1ns/1ps
`default_nettype none

module srt_router (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [1:0] variant_i,
    input wire logic [1:0] form_i,
    input wire logic low_speed_port_i,
    input wire logic req_valid_i,
    input wire srt_pkg::srt_req_s req_i,
    input wire logic release_i,
    input wire logic release_port_i,
    input wire logic [7:0] sync_line_i,
    input wire logic chassis_star_trigger_i,
    input wire logic chassis_ref_clock_i,
    input wire logic local_timebase_i,
    input wire logic local_resync_i,
    input wire logic start_event_i,
    input wire logic [1:0] rx_event_i,
    input wire logic [1:0] transceiver_fault_n_i,
    output logic req_ack_o,
    output logic req_err_o,
    output logic [7:0] sync_line_o,
    output logic [7:0] sync_line_oe_o,
    output logic trigger_pin_o,
    output logic clock_pin_o,
    output logic start_trigger_o,
    output logic resync_pulse_o,
    output logic ext_timebase_o,
    output logic ext_timebase_sel_o
);

    localparam int ND = srt_pkg::NUM_DST;
    localparam int NL = srt_pkg::NUM_LINES;
    localparam logic [11:0] FLT_LAST = 12'(srt_pkg::MIN_PULSE_CYC - 1);
    localparam logic [3:0] TB_LAST = 4'(srt_pkg::USB_TB_HALF - 1);

    function automatic logic [2:0] pop7(input logic [6:0] v);
        logic [2:0] s;
        s = 3'h0;
        for (int i = 0; i < 7; i++) begin
            s = s + {2'h0, v[i]};
        end
        return s;
    endfunction

    // Variant decode.
    wire gen1 = variant_i == srt_pkg::VAR_GEN1;
    wire gen2 = variant_i == srt_pkg::VAR_GEN2;
    wire usb = variant_i == srt_pkg::VAR_USB;
    wire pcmcia = form_i == srt_pkg::FF_PCMCIA;
    wire chassis = form_i == srt_pkg::FF_CHASSIS;

    // Synchronisers for inputs from other cards and the chassis.
    logic [9:0] meta_q;
    logic [9:0] sync_q;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            meta_q <= 10'h000;
            sync_q <= 10'h000;
        end else begin
            meta_q <= {chassis_ref_clock_i, chassis_star_trigger_i,
                       sync_line_i};
            sync_q <= meta_q;
        end
    end

    // First generation inputs are slow and wide, so a line only changes
    // after it has held a new level for the least pulse width; faster
    // activity is rejected, which is why fast timebases cannot be taken.
    logic [NL-1:0] flt_q;
    logic [NL-1:0] line_in;
    genvar n;
    generate
        for (n = 0; n < NL; n++) begin : g_flt
            logic [11:0] cnt_q;
            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    cnt_q <= 12'h000;
                    flt_q[n] <= 1'b0;
                end else if (sync_q[n] == flt_q[n]) begin
                    cnt_q <= 12'h000;
                end else if (cnt_q == FLT_LAST) begin
                    cnt_q <= 12'h000;
                    flt_q[n] <= sync_q[n];
                end else begin
                    cnt_q <= cnt_q + 12'h001;
                end
            end
            assign line_in[n] = gen1 ? flt_q[n] : sync_q[n];
        end
    endgenerate

    // The USB variant can only drive a 1 MHz square wave as timebase.
    logic [3:0] tb_cnt_q;
    logic tb_usb_q;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            tb_cnt_q <= 4'h0;
            tb_usb_q <= 1'b0;
        end else if (tb_cnt_q == TB_LAST) begin
            tb_cnt_q <= 4'h0;
            tb_usb_q <= ~tb_usb_q;
        end else begin
            tb_cnt_q <= tb_cnt_q + 4'h1;
        end
    end
    wire tb_out = usb ? tb_usb_q : local_timebase_i;

    // Source levels for each port; only the receive and fault events differ by port.
    logic [15:0] src_vec [2];
    generate
        for (n = 0; n < 2; n++) begin : g_src
            assign src_vec[n] = {1'b0, start_event_i,
                                 ~transceiver_fault_n_i[n],
                                 rx_event_i[n],
                                 local_resync_i, tb_out,
                                 sync_q[9], sync_q[8], line_in};
        end
    endgenerate

    // Route table, one entry per destination.
    logic [ND-1:0] dst_en_q;
    logic [3:0] dst_src_q [ND];
    logic [ND-1:0] dst_port_q;

    // Request decode.
    wire [3:0] rs = req_i.src;
    wire [3:0] rd = req_i.dst;
    wire s_line = rs < srt_pkg::SRC_CLK_LINE;
    wire d_line = rd < srt_pkg::DST_CLK_LINE;
    wire [2:0] req_line = s_line ? rs[2:0] : rd[2:0];
    wire d_start = rd == srt_pkg::DST_START;
    wire d_resync = rd == srt_pkg::DST_RESYNC;
    wire d_mtb = rd == srt_pkg::DST_MTB;
    wire d_clk = rd == srt_pkg::DST_CLK_LINE;
    wire s_clk = rs == srt_pkg::SRC_CLK_LINE;
    wire s_resync = rs == srt_pkg::SRC_RESYNC;
    wire s_startev = rs == srt_pkg::SRC_START_EVT;
    wire s_star = rs == srt_pkg::SRC_STAR;
    wire s_ref = rs == srt_pkg::SRC_REF10;
    wire s_tb = rs == srt_pkg::SRC_TB20;
    wire s_rx = rs == srt_pkg::SRC_RX_EVT;
    wire s_xcvr = rs == srt_pkg::SRC_XCVR_EVT;

    // Permitted pairs per generation.
    wire pair_g1 = (s_line & d_resync) | (s_line & d_start) |
                   (s_resync & d_line) | (s_resync & d_start) |
                   (s_startev & d_line);
    wire pair_g2 = pair_g1 | (s_clk & d_mtb) | (s_star & d_start) |
                   (s_ref & d_mtb) | (s_tb & d_clk) |
                   (s_rx & (d_line | d_start)) |
                   (s_xcvr & d_line);
    wire pair_usb = (s_line & d_start) | (s_clk & d_mtb) |
                    (s_tb & d_clk) | (s_startev & d_line);
    wire pair_ok = gen1 ? pair_g1 : gen2 ? pair_g2 : usb & pair_usb;

    // Terminals the card offers.
    wire line_ok = !(gen1 & chassis & req_line == 3'h6) &
                   !(gen2 & pcmcia & req_line >= 3'h4) &
                   !(usb & req_line != 3'h0);
    wire chas_ok = !((s_star | s_ref) & gen2 & !chassis);
    wire tb_ok = !(s_tb & gen2 & pcmcia);
    wire xcvr_ok = !s_xcvr | (rd[0] == req_i.port);
    wire term_ok = ((!s_line & !d_line) | line_ok) & chas_ok & tb_ok &
                   xcvr_ok;

    // Line counts, ignoring the entry that the request would replace.
    logic [6:0] in_mask;
    always_comb begin
        in_mask = 7'h00;
        for (int d = 9; d < 11; d++) begin
            if (dst_en_q[d] && dst_src_q[d] < srt_pkg::SRC_CLK_LINE &&
                rd != 4'(d)) begin
                in_mask[dst_src_q[d][2:0]] = 1'b1;
            end
        end
    end
    wire [6:0] req_bit = 7'h01 << req_line;
    wire [6:0] in_new = in_mask | (s_line ? req_bit : 7'h00);
    wire [6:0] out_new = dst_en_q[6:0] | (d_line ? req_bit : 7'h00);
    wire [2:0] max_in = !gen1 ? srt_pkg::NO_LIMIT :
                        low_speed_port_i ? srt_pkg::LS_MAX_IN :
                        srt_pkg::HS_MAX_IN;
    wire [2:0] max_out = !gen1 ? srt_pkg::NO_LIMIT :
                         low_speed_port_i ? srt_pkg::LS_MAX_OUT :
                         srt_pkg::HS_MAX_OUT;
    wire count_ok = pop7(in_new) <= max_in &
                    pop7(out_new) <= max_out;

    // A request is checked as a whole before any entry is touched.
    wire conn_ok = req_i.connect & pair_ok & term_ok & count_ok;
    wire disc_hit = !req_i.connect & rd < 4'(ND) & dst_en_q[rd] &
                    dst_src_q[rd] == rs;
    wire req_ok = conn_ok | disc_hit;

    logic [ND-1:0] sel_level;
    genvar d;
    generate
        for (d = 0; d < ND; d++) begin : g_route
            wire hit = req_valid_i & rd == 4'(d);
            wire rel = release_i & dst_port_q[d] == release_port_i;
            always_ff @(posedge clk_i) begin
                if (!rstn_i) begin
                    dst_en_q[d] <= 1'b0;
                    dst_src_q[d] <= srt_pkg::SRC_RST;
                    dst_port_q[d] <= 1'b0;
                end else if (rel) begin
                    dst_en_q[d] <= 1'b0;
                end else if (hit & conn_ok) begin
                    dst_en_q[d] <= 1'b1;
                    dst_src_q[d] <= rs;
                    dst_port_q[d] <= req_i.port;
                end else if (hit & disc_hit) begin
                    dst_en_q[d] <= 1'b0;
                end
            end
            assign sel_level[d] = dst_en_q[d] &
                src_vec[dst_port_q[d]][dst_src_q[d]];
        end
    endgenerate

    // Start trigger arms when routed and fires once on the first rise.
    logic start_prev_q;
    logic start_done_q;
    logic resync_prev_q;
    wire start_touch = (req_valid_i & d_start & req_ok) |
                       (release_i & dst_port_q[10] == release_port_i);
    wire start_rise = sel_level[10] & !start_prev_q & !start_done_q;
    wire resync_rise = sel_level[9] & !resync_prev_q;
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            start_prev_q <= 1'b0;
            start_done_q <= 1'b0;
            start_trigger_o <= 1'b0;
        end else begin
            start_prev_q <= sel_level[10];
            start_trigger_o <= start_rise & !start_touch;
            if (start_touch) begin
                start_done_q <= 1'b0;
            end else if (start_rise) begin
                start_done_q <= 1'b1;
            end
        end
    end

    // The timebase is realigned on every resync rise, not just the first.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            resync_prev_q <= 1'b0;
            resync_pulse_o <= 1'b0;
        end else begin
            resync_prev_q <= sel_level[9];
            resync_pulse_o <= resync_rise;
        end
    end

    // Line drivers and remaining outputs, all registered.
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sync_line_o <= 8'h00;
            sync_line_oe_o <= 8'h00;
            trigger_pin_o <= 1'b0;
            clock_pin_o <= 1'b0;
            ext_timebase_o <= 1'b0;
            ext_timebase_sel_o <= 1'b0;
            req_ack_o <= 1'b0;
            req_err_o <= 1'b0;
        end else begin
            sync_line_o <= sel_level[7:0];
            sync_line_oe_o <= dst_en_q[7:0];
            trigger_pin_o <= usb & sel_level[0];
            clock_pin_o <= usb & sel_level[7];
            ext_timebase_o <= sel_level[8];
            ext_timebase_sel_o <= dst_en_q[8];
            req_ack_o <= req_valid_i;
            req_err_o <= req_valid_i & !req_ok;
        end
    end

endmodule

`default_nettype wire

/* rtl/srt_pkg.sv */
// Package with terminal codes, variant codes, request carrier and timing.
package srt_pkg;

    localparam int NUM_LINES = 8;
    localparam int NUM_DST = 11;

    // Source terminal codes; values below SRC_CLK_LINE are general lines.
    localparam logic [3:0] SRC_CLK_LINE = 4'h7;
    localparam logic [3:0] SRC_STAR = 4'h8;
    localparam logic [3:0] SRC_REF10 = 4'h9;
    localparam logic [3:0] SRC_TB20 = 4'hA;
    localparam logic [3:0] SRC_RESYNC = 4'hB;
    localparam logic [3:0] SRC_RX_EVT = 4'hC;
    localparam logic [3:0] SRC_XCVR_EVT = 4'hD;
    localparam logic [3:0] SRC_START_EVT = 4'hE;

    // Destination terminal codes; values below DST_CLK_LINE are lines.
    localparam logic [3:0] DST_CLK_LINE = 4'h7;
    localparam logic [3:0] DST_MTB = 4'h8;
    localparam logic [3:0] DST_RESYNC = 4'h9;
    localparam logic [3:0] DST_START = 4'hA;

    // Hardware generation and form factor codes.
    localparam logic [1:0] VAR_GEN1 = 2'h0;
    localparam logic [1:0] VAR_GEN2 = 2'h1;
    localparam logic [1:0] VAR_USB = 2'h2;
    localparam logic [1:0] FF_PCI = 2'h0;
    localparam logic [1:0] FF_CHASSIS = 2'h1;
    localparam logic [1:0] FF_PCMCIA = 2'h2;
    localparam logic [1:0] FF_USB = 2'h3;

    // Line-count limits of the first generation.
    localparam logic [2:0] HS_MAX_IN = 3'h4;
    localparam logic [2:0] HS_MAX_OUT = 3'h4;
    localparam logic [2:0] LS_MAX_IN = 3'h2;
    localparam logic [2:0] LS_MAX_OUT = 3'h3;
    localparam logic [2:0] NO_LIMIT = 3'h7;

    // Timing.
    localparam int CLK_HZ = 20_000_000;
    localparam int MIN_PULSE_NS = 100_000;
    localparam int MIN_PULSE_CYC =
        (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int USB_TB_HZ = 1_000_000;
    localparam int USB_TB_HALF = CLK_HZ / (2 * USB_TB_HZ);

    // Reset values.
    localparam logic [3:0] SRC_RST = 4'h0;

    typedef struct packed {
        logic connect;
        logic [3:0] src;
        logic [3:0] dst;
        logic port;
    } srt_req_s;

endpackage

/* sim/srt_router_sva.sv */
// Checker of the routing block's request answers and line enables.
`timescale 1ns/1ps
`default_nettype none
module srt_router_sva (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [1:0] variant_i,
    input wire logic [1:0] form_i,
    input wire logic low_speed_port_i,
    input wire logic req_valid_i,
    input wire logic release_i,
    input wire logic req_ack_o,
    input wire logic req_err_o,
    input wire logic [7:0] sync_line_oe_o,
    input wire logic start_trigger_o,
    input wire logic resync_pulse_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_ack_follows: assert property (req_valid_i |=> req_ack_o)
        else $error("ack missing");
    a_ack_unasked: assert property (!req_valid_i |=> !req_ack_o)
        else $error("ack without request");
    a_err_with_ack: assert property (req_err_o |-> req_ack_o)
        else $error("err without ack");
    // A release in the same cycle may legally change the enables.
    a_err_keeps: assert property (req_err_o && !$past(release_i)
        |=> $stable(sync_line_oe_o)) else $error("refused request routed");
    a_start_single: assert property (start_trigger_o |=> !start_trigger_o)
        else $error("start trigger too long");
    a_resync_single: assert property (resync_pulse_o |=> !resync_pulse_o)
        else $error("resync pulse too long");
    a_chassis_six: assert property (variant_i == 2'h0
        && form_i == 2'h1 |-> !sync_line_oe_o[6]) else $error("line 6 used");
    a_pcmcia_lines: assert property (variant_i == 2'h1
        && form_i == 2'h2 |-> sync_line_oe_o[6:4] == 3'h0)
        else $error("missing line driven");
    a_usb_lines: assert property (variant_i == 2'h2
        |-> sync_line_oe_o[6:1] == 6'h00) else $error("usb line driven");
    a_out_limit: assert property (variant_i == 2'h0
        |-> $countones(sync_line_oe_o[6:0])
        <= (low_speed_port_i ? 3 : 4)) else $error("too many outputs");
endmodule
`default_nettype wire

/* sim/srt_far_card.sv */
// Model of another card sharing the sync lines, with a link clock on line 5.
`timescale 1ns/1ps
`default_nettype none
module srt_far_card (
    input wire logic [7:0] drive_i,
    input wire logic [7:0] dev_line_i,
    input wire logic [7:0] dev_oe_i,
    input wire logic run_i,
    output logic [7:0] line_o
);
    logic lclk;
    logic [7:0] far;
    // The link clock stands low between frames and has its own phase.
    initial begin
        lclk = 1'h0;
        #37;
        forever begin
            #200;
            lclk = run_i ? ~lclk : 1'h0;
        end
    end
    assign far = drive_i | {2'h0, lclk, 5'h00};
    assign line_o = (dev_oe_i & dev_line_i) | (~dev_oe_i & far);
endmodule
`default_nettype wire

/* sim/srt_router_tb_top.sv */
// Self-checking bench of the sync line and trigger routing block.
`timescale 1ns/1ps
`default_nettype none
module srt_router_tb_top;
    logic clk_i, rstn_i, ls, vld, rel, rel_p, run, sevt;
    logic [1:0] var_s, ff, rx, flt_n;
    logic [7:0] drv, line_i, line_o, oe;
    logic ack, err, trg, cpin, st, rs, etb, esel;
    srt_pkg::srt_req_s req;
    int errors = 0, cmp_count = 0, n_st = 0, n_rs = 0;

    srt_router srt_router_inst (
        .clk_i(clk_i), .rstn_i(rstn_i), .variant_i(var_s), .form_i(ff),
        .low_speed_port_i(ls), .req_valid_i(vld), .req_i(req),
        .release_i(rel), .release_port_i(rel_p), .sync_line_i(line_i),
        .chassis_star_trigger_i(1'h0), .chassis_ref_clock_i(1'h0),
        .local_timebase_i(1'h0), .local_resync_i(1'h0),
        .start_event_i(sevt), .rx_event_i(rx), .transceiver_fault_n_i(flt_n),
        .req_ack_o(ack), .req_err_o(err), .sync_line_o(line_o),
        .sync_line_oe_o(oe), .trigger_pin_o(trg), .clock_pin_o(cpin),
        .start_trigger_o(st), .resync_pulse_o(rs), .ext_timebase_o(etb),
        .ext_timebase_sel_o(esel));
    srt_far_card srt_far_card_inst (.drive_i(drv), .dev_line_i(line_o),
        .dev_oe_i(oe), .run_i(run), .line_o(line_i));

    initial begin
        clk_i = 1'h0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        n_st <= n_st + int'(st === 1'h1);
        n_rs <= n_rs + int'(rs === 1'h1);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic reboot(input logic [1:0] v, f, input logic l);
        @(posedge clk_i);
        rstn_i <= 1'h0;
        drv <= 8'h00;
        var_s <= v;
        ff <= f;
        ls <= l;
        wt(10);
        rstn_i <= 1'h1;
    endtask
    task automatic rq(input logic [3:0] s, d, input logic p, e,
                      input logic c = 1'h1);
        @(posedge clk_i);
        vld <= 1'h1;
        req <= '{c, s, d, p};
        @(posedge clk_i);
        vld <= 1'h0;
        #1 chk({6'h00, ack, err}, {7'h01, e});
    endtask
    task automatic t_gen2();
        int b;
        reboot(2'h1, 2'h0, 1'h0);
        rq(4'h0, 4'hA, 1'h0, 1'h0);
        b = n_st;
        wt(1);
        drv <= 8'h01;
        wt(10);
        drv <= 8'h00;
        wt(10);
        drv <= 8'h01;
        wt(10);
        #1 chk(8'(n_st - b), 8'h01);
        rq(4'h8, 4'hA, 1'h0, 1'h1);
        rq(4'h9, 4'h8, 1'h0, 1'h1);
        rq(4'hD, 4'h1, 1'h0, 1'h1);
        rq(4'hD, 4'h2, 1'h0, 1'h0);
        rq(4'hD, 4'h1, 1'h1, 1'h0);
        rq(4'hC, 4'h3, 1'h0, 1'h0);
        rq(4'hB, 4'h9, 1'h0, 1'h1);
        wt(1);
        rx <= 2'h1;
        flt_n <= 2'h2;
        wt(4);
        #1 chk({2'h0, oe[3:1], line_o[3:1]}, 8'h3E);
        wt(1);
        rx <= 2'h0;
        flt_n <= 2'h3;
        rq(4'hA, 4'h7, 1'h0, 1'h0);
        rq(4'h7, 4'h8, 1'h0, 1'h0);
        wt(1);
        #1 chk(8'(esel), 8'h01);
        rq(4'h5, 4'h9, 1'h0, 1'h0);
        b = n_rs;
        wt(1);
        run <= 1'h1;
        wt(80);
        run <= 1'h0;
        wt(20);
        #1 chk(8'(n_rs - b), 8'h0A);
        wt(1);
        rel <= 1'h1;
        rel_p <= 1'h0;
        wt(1);
        rel <= 1'h0;
        wt(3);
        #1 chk(oe, 8'h02);
    endtask
    task automatic t_gen1();
        int b;
        reboot(2'h0, 2'h1, 1'h0);
        rq(4'hB, 4'h6, 1'h0, 1'h1);
        for (int i = 0; i < 4; i++) rq(4'hB, 4'(i), 1'h0, 1'h0);
        rq(4'hB, 4'h4, 1'h0, 1'h1);
        rq(4'hA, 4'h7, 1'h0, 1'h1);
        rq(4'h5, 4'hA, 1'h0, 1'h0);
        b = n_st;
        wt(1);
        // The first pulse is deliberately too short to be seen.
        drv <= 8'h20;
        wt(1000);
        drv <= 8'h00;
        wt(10000);
        drv <= 8'h20;
        wt(10000);
        #1 chk(8'(n_st - b), 8'h01);
        reboot(2'h0, 2'h0, 1'h1);
        for (int i = 0; i < 3; i++) rq(4'hB, 4'(i), 1'h0, 1'h0);
        rq(4'hB, 4'h3, 1'h0, 1'h1);
        rq(4'h0, 4'h9, 1'h0, 1'h0);
    endtask
    task automatic t_pcmcia();
        reboot(2'h1, 2'h2, 1'h0);
        rq(4'hA, 4'h7, 1'h0, 1'h1);
        rq(4'h8, 4'hA, 1'h0, 1'h1);
        rq(4'h9, 4'h8, 1'h0, 1'h1);
        rq(4'hB, 4'h4, 1'h0, 1'h1);
        rq(4'h6, 4'hA, 1'h0, 1'h1);
        rq(4'hB, 4'h3, 1'h0, 1'h0);
        wt(1);
        #1 chk(oe, 8'h08);
        rq(4'hB, 4'h3, 1'h0, 1'h0, 1'h0);
        rq(4'hB, 4'h3, 1'h0, 1'h1, 1'h0);
        wt(1);
        #1 chk(oe, 8'h00);
    endtask
    task automatic t_usb();
        int n, m, k;
        logic p, q, r;
        reboot(2'h2, 2'h3, 1'h0);
        rq(4'h1, 4'hA, 1'h0, 1'h1);
        rq(4'hB, 4'h0, 1'h0, 1'h1);
        rq(4'h0, 4'hA, 1'h0, 1'h0);
        rq(4'h7, 4'h8, 1'h0, 1'h0);
        rq(4'hA, 4'h7, 1'h0, 1'h0);
        rq(4'hE, 4'h0, 1'h0, 1'h0);
        // Let the routed timebase settle on every copy before counting.
        wt(10);
        n = 0;
        m = 0;
        k = 0;
        {p, q, r} = {line_o[7], cpin, etb};
        for (int i = 0; i < 200; i++) begin
            @(negedge clk_i);
            n += int'(line_o[7] !== p);
            m += int'(cpin !== q);
            k += int'(etb !== r);
            {p, q, r} = {line_o[7], cpin, etb};
        end
        chk(8'(n), 8'h14);
        chk(8'(m), 8'h14);
        chk(8'(k), 8'h14);
        wt(1);
        sevt <= 1'h1;
        wt(4);
        #1 chk({6'h00, trg, esel}, 8'h03);
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        {rstn_i, ls, vld, rel, rel_p, run, sevt} = 7'h00;
        {var_s, ff, rx} = 6'h00;
        flt_n = 2'h3;
        drv = 8'h00;
        req = '0;
        t_gen2();
        t_gen1();
        t_pcmcia();
        t_usb();
        wrap_up();
    end
    initial begin
        #3_000_000;
        errors++;
        wrap_up();
    end
endmodule
bind srt_router srt_router_sva srt_router_sva_inst (.clk_i(clk_i),
    .rstn_i(rstn_i), .variant_i(variant_i), .form_i(form_i),
    .low_speed_port_i(low_speed_port_i), .req_valid_i(req_valid_i),
    .release_i(release_i), .req_ack_o(req_ack_o), .req_err_o(req_err_o),
    .sync_line_oe_o(sync_line_oe_o), .start_trigger_o(start_trigger_o),
    .resync_pulse_o(resync_pulse_o));
`default_nettype wire
